// File: common/iom_pkg.sv
// Purpose: Shared constants for the I/O pin function multiplexer
// Assumes: 32 pins, eight peripheral functions A to H
// Notes: Offsets are byte addresses on the register bus
package iom_pkg;
  // ---------------------------------------------------------------
  // Sizes
  // ---------------------------------------------------------------
  localparam int NPIN = 32;
  localparam int NFUNC = 8;
  localparam int AW = 8;
  // ---------------------------------------------------------------
  // Register offsets
  // ---------------------------------------------------------------
  localparam logic [7:0] OFF_DIR = 8'h00;
  localparam logic [7:0] OFF_OUT = 8'h04;
  localparam logic [7:0] OFF_IN = 8'h08;
  localparam logic [7:0] OFF_STAT = 8'h0C;
  localparam logic [7:0] OFF_PMUX = 8'h40;
  localparam logic [7:0] OFF_CFG = 8'h80;
  // Region codes from the address decoder
  localparam logic [2:0] RG_NONE = 3'h0;
  localparam logic [2:0] RG_DIR = 3'h1;
  localparam logic [2:0] RG_OUT = 3'h2;
  localparam logic [2:0] RG_IN = 3'h3;
  localparam logic [2:0] RG_STAT = 3'h4;
  localparam logic [2:0] RG_PMUX = 3'h5;
  localparam logic [2:0] RG_CFG = 3'h6;
  // ---------------------------------------------------------------
  // Field layout
  // ---------------------------------------------------------------
  localparam int CFG_EN_BIT = 0;
  localparam int CFG_INEN_BIT = 1;
  localparam int PMUX_EVEN_LSB = 0;
  localparam int PMUX_ODD_LSB = 4;
  // ---------------------------------------------------------------
  // Function codes and fixed pins
  // ---------------------------------------------------------------
  localparam logic [3:0] FUNC_B = 4'h1;
  localparam logic [3:0] FUNC_C = 4'h2;
  localparam logic [3:0] FUNC_G = 4'h6;
  localparam logic [3:0] FUNC_H = 4'h7;
  localparam int PIN_DBG_CLK = 30;
  localparam int PIN_DBG_DATA = 31;
  localparam int PMUX_DBG_IDX = 15;
  localparam logic [31:0] DBG_PIN_MASK = 32'hC000_0000;
  localparam logic [31:0] XOSC_PIN_MASK = 32'h0000_C000;
  localparam logic [31:0] XOSC32_PIN_MASK = 32'h0000_0003;
  // ---------------------------------------------------------------
  // Reset values and bus response codes
  // ---------------------------------------------------------------
  localparam logic [31:0] RST_DIR = 32'h0000_0000;
  localparam logic [31:0] RST_OUT = 32'h0000_0000;
  localparam logic [31:0] RST_CFG_EN = 32'h4000_0000;
  localparam logic [3:0] RST_SEL = 4'h0;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage : iom_pkg

// File: hdl/iom_pin_slice.sv
// Purpose: Output stage of one pin: port, peripheral, analog or oscillator
// Assumes: Function choice already qualified by the caller
// Notes: Every output is registered
`timescale 1ns/1ns
module iom_pin_slice (
  input wire logic mclk,
  input wire logic reset,
  input wire logic ce,
  input wire logic gpio_out,
  input wire logic gpio_dir,
  input wire logic gpio_inen,
  input wire logic func_act,
  input wire logic [3:0] func_sel,
  input wire logic osc_own,
  input wire logic [7:0] fn_out,
  input wire logic [7:0] fn_oe,
  input wire logic pad_in,
  output logic pad_out,
  output logic pad_oe,
  output logic pad_ie,
  output logic pad_analog_en,
  output logic fn_active,
  output logic fn_in
);
  // ---------------------------------------------------------------
  // Pin ownership
  // ---------------------------------------------------------------
  // Oscillator first, then analog, then digital function, then port
  always_ff @(posedge mclk) begin
    if (reset) begin
      pad_out <= 1'b0;
      pad_oe <= 1'b0;
      pad_ie <= 1'b0;
      pad_analog_en <= 1'b0;
      fn_active <= 1'b0;
      fn_in <= 1'b0;
    end else if (ce) begin
      if (osc_own) begin
        pad_out <= 1'b0;
        pad_oe <= 1'b0;
        pad_ie <= 1'b0;
        pad_analog_en <= 1'b1;
        fn_active <= 1'b0;
        fn_in <= 1'b0;
      end else if (func_act && func_sel == iom_pkg::FUNC_B) begin
        pad_out <= 1'b0;
        pad_oe <= 1'b0;
        pad_ie <= 1'b0;
        pad_analog_en <= 1'b1;
        fn_active <= 1'b1;
        fn_in <= 1'b0;
      end else if (func_act) begin
        pad_out <= fn_out[func_sel[2:0]];
        pad_oe <= fn_oe[func_sel[2:0]];
        pad_ie <= 1'b1;
        pad_analog_en <= 1'b0;
        fn_active <= 1'b1;
        fn_in <= pad_in;
      end else begin
        pad_out <= gpio_out;
        pad_oe <= gpio_dir;
        pad_ie <= gpio_inen;
        pad_analog_en <= 1'b0;
        fn_active <= 1'b0;
        fn_in <= 1'b0;
      end
    end
  end
endmodule : iom_pin_slice

// File: hdl/iom_pin_mux.sv
// Purpose: Pin function multiplexer with port registers and debug takeover
// Assumes: AXI4-Lite slave plus a single-cycle processor I/O bus
// Notes: Peripheral buses are flat, function f of pin n at f*32+n
`timescale 1ns/1ns
// How it works
// - A pin with no enabled function stays under port direction and output control.
// - A function reaches a pin only while its pin_config_n enable bit is one.
// - The even or odd select field of the shared mux register picks function A to H.
// - Function B cuts the digital driver and input so only the analog user has the pin.
// - The debug data function on pin 31 is live only while a debugger is present.
// - Reset hands pin 30 to the debug clock function so a probe can be seen.
// - Software may later move pin 30 to port control or another function.
// - Pin 31 is a plain pin until a debugger attaches, then takes the debug data function.
// - In debug mode software reads and writes of pins 30 and 31 port state are ignored.
// - Oscillator pins follow the system controller, not the function select.
// - The processor I/O bus completes each 32-bit load or store in one cycle.
module iom_pin_mux (
  input wire logic mclk,
  input wire logic reset,
  input wire logic ce,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic [2:0] s_axi_awprot,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  output logic [1:0] s_axi_bresp,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic [2:0] s_axi_arprot,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  input wire logic iob_sel,
  input wire logic iob_we,
  input wire logic [7:0] iob_addr,
  input wire logic [31:0] iob_wdata,
  output logic [31:0] iob_rdata,
  input wire logic debugger_present,
  input wire logic debug_mode,
  input wire logic osc_xosc_en,
  input wire logic osc_xosc32k_en,
  input wire logic [31:0] pad_in,
  output logic [31:0] pad_out,
  output logic [31:0] pad_oe,
  output logic [31:0] pad_ie,
  output logic [31:0] pad_analog_en,
  input wire logic [255:0] periph_out,
  input wire logic [255:0] periph_oe,
  output logic [31:0] periph_in,
  output logic [31:0] periph_func_active
);
  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  logic [31:0] dir_reg;
  logic [31:0] out_reg;
  logic [31:0] in_reg;
  logic [31:0] cfg_en_reg;
  logic [31:0] cfg_inen_reg;
  logic [3:0] sel_reg [iom_pkg::NPIN];
  logic dbg_prev_reg;
  logic wpend_reg;
  logic [7:0] waddr_reg;
  logic [31:0] wdata_reg;
  logic [3:0] wstrb_reg;
  logic [31:0] pin_act;
  logic [31:0] osc_own;
  logic [31:0] lock;
  logic iob_wr;
  logic wp_en;
  logic [7:0] wp_addr;
  logic [31:0] wp_data;
  logic [31:0] wp_mask;

  // ---------------------------------------------------------------
  // Decoding
  // ---------------------------------------------------------------
  // Region of an address, shared by reads and writes on both buses
  function automatic logic [2:0] region(input logic [7:0] a);
    if (a[1:0] != 2'h0) begin
      region = iom_pkg::RG_NONE;
    end else if (a[7]) begin
      region = iom_pkg::RG_CFG;
    end else if (a[6]) begin
      region = iom_pkg::RG_PMUX;
    end else if (a == iom_pkg::OFF_DIR) begin
      region = iom_pkg::RG_DIR;
    end else if (a == iom_pkg::OFF_OUT) begin
      region = iom_pkg::RG_OUT;
    end else if (a == iom_pkg::OFF_IN) begin
      region = iom_pkg::RG_IN;
    end else if (a == iom_pkg::OFF_STAT) begin
      region = iom_pkg::RG_STAT;
    end else begin
      region = iom_pkg::RG_NONE;
    end
  endfunction : region

  // Read value; debug pins read as zero while locked
  function automatic logic [31:0] read_word(input logic [7:0] a);
    logic [4:0] n;
    logic [3:0] k;
    n = a[6:2];
    k = a[5:2];
    read_word = 32'h0000_0000;
    case (region(a))
      iom_pkg::RG_DIR: read_word = dir_reg & ~lock;
      iom_pkg::RG_OUT: read_word = out_reg & ~lock;
      iom_pkg::RG_IN: read_word = in_reg & ~lock;
      iom_pkg::RG_STAT: read_word = {29'h0, pin_act[31], debugger_present, debug_mode};
      iom_pkg::RG_PMUX: begin
        if (!(debug_mode && k == 4'(iom_pkg::PMUX_DBG_IDX))) begin
          read_word = {24'h0, sel_reg[{k, 1'b1}], sel_reg[{k, 1'b0}]};
        end
      end
      iom_pkg::RG_CFG: begin
        if (!lock[n]) begin
          read_word = {30'h0, cfg_inen_reg[n], cfg_en_reg[n]};
        end
      end
      default: read_word = 32'h0000_0000;
    endcase
  endfunction : read_word

  // Debug lock and oscillator ownership
  assign lock = debug_mode ? iom_pkg::DBG_PIN_MASK : 32'h0000_0000;
  assign osc_own = (osc_xosc_en ? iom_pkg::XOSC_PIN_MASK : 32'h0000_0000)
                 | (osc_xosc32k_en ? iom_pkg::XOSC32_PIN_MASK : 32'h0000_0000);

  // ---------------------------------------------------------------
  // Write port: I/O bus first, parked AXI write otherwise
  // ---------------------------------------------------------------
  assign iob_wr = iob_sel && iob_we;
  assign wp_en = iob_wr || wpend_reg;
  assign wp_addr = iob_wr ? iob_addr : waddr_reg;
  assign wp_data = iob_wr ? iob_wdata : wdata_reg;
  assign wp_mask = iob_wr ? 32'hFFFF_FFFF
                 : {{8{wstrb_reg[3]}}, {8{wstrb_reg[2]}}, {8{wstrb_reg[1]}}, {8{wstrb_reg[0]}}};

  // Port direction and output
  always_ff @(posedge mclk) begin
    if (reset) begin
      dir_reg <= iom_pkg::RST_DIR;
      out_reg <= iom_pkg::RST_OUT;
    end else if (ce && wp_en) begin
      if (region(wp_addr) == iom_pkg::RG_DIR) begin
        dir_reg <= (dir_reg & ~(wp_mask & ~lock)) | (wp_data & wp_mask & ~lock);
      end
      if (region(wp_addr) == iom_pkg::RG_OUT) begin
        out_reg <= (out_reg & ~(wp_mask & ~lock)) | (wp_data & wp_mask & ~lock);
      end
    end
  end

  // Input sampling
  always_ff @(posedge mclk) begin
    if (reset) begin
      in_reg <= 32'h0000_0000;
    end else if (ce) begin
      in_reg <= pad_in;
    end
  end

  // Pin configuration and function select, with debugger takeover
  always_ff @(posedge mclk) begin
    if (reset) begin
      cfg_en_reg <= iom_pkg::RST_CFG_EN;
      cfg_inen_reg <= 32'h0000_0000;
      for (int i = 0; i < iom_pkg::NPIN; i++) begin
        sel_reg[i] <= (i == iom_pkg::PIN_DBG_CLK) ? iom_pkg::FUNC_G : iom_pkg::RST_SEL;
      end
      dbg_prev_reg <= 1'b0;
    end else if (ce) begin
      dbg_prev_reg <= debugger_present;
      if (wp_en && wp_mask[0] && region(wp_addr) == iom_pkg::RG_CFG
          && !lock[wp_addr[6:2]]) begin
        cfg_en_reg[wp_addr[6:2]] <= wp_data[iom_pkg::CFG_EN_BIT];
        cfg_inen_reg[wp_addr[6:2]] <= wp_data[iom_pkg::CFG_INEN_BIT];
      end
      if (wp_en && wp_mask[0] && region(wp_addr) == iom_pkg::RG_PMUX
          && !(debug_mode && wp_addr[5:2] == 4'(iom_pkg::PMUX_DBG_IDX))) begin
        sel_reg[{wp_addr[5:2], 1'b0}] <= wp_data[iom_pkg::PMUX_EVEN_LSB +: 4];
        sel_reg[{wp_addr[5:2], 1'b1}] <= wp_data[iom_pkg::PMUX_ODD_LSB +: 4];
      end
      // Attach wins over a software write in the same cycle
      if (debugger_present && !dbg_prev_reg) begin
        cfg_en_reg[iom_pkg::PIN_DBG_DATA] <= 1'b1;
        sel_reg[iom_pkg::PIN_DBG_DATA] <= iom_pkg::FUNC_H;
      end
    end
  end

  // ---------------------------------------------------------------
  // AXI4-Lite write channel
  // ---------------------------------------------------------------
  // Address and data taken together, parked, committed, then answered
  always_ff @(posedge mclk) begin
    if (reset) begin
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= iom_pkg::RESP_OKAY;
      wpend_reg <= 1'b0;
      waddr_reg <= 8'h00;
      wdata_reg <= 32'h0000_0000;
      wstrb_reg <= 4'h0;
    end else if (ce) begin
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      if (s_axi_awready && s_axi_wready) begin
        wpend_reg <= 1'b1;
        waddr_reg <= s_axi_awaddr;
        wdata_reg <= s_axi_wdata;
        wstrb_reg <= s_axi_wstrb;
      end else if (wpend_reg && !iob_wr) begin
        wpend_reg <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= (region(waddr_reg) == iom_pkg::RG_NONE) ? iom_pkg::RESP_SLVERR
                                                               : iom_pkg::RESP_OKAY;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end else if (s_axi_awvalid && s_axi_wvalid && !s_axi_awready && !wpend_reg
                   && !s_axi_bvalid) begin
        s_axi_awready <= 1'b1;
        s_axi_wready <= 1'b1;
      end
    end
  end

  // ---------------------------------------------------------------
  // AXI4-Lite read channel and I/O bus read
  // ---------------------------------------------------------------
  always_ff @(posedge mclk) begin
    if (reset) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= iom_pkg::RESP_OKAY;
    end else if (ce) begin
      s_axi_arready <= 1'b0;
      if (s_axi_arready && s_axi_arvalid) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= read_word(s_axi_araddr);
        s_axi_rresp <= (region(s_axi_araddr) == iom_pkg::RG_NONE) ? iom_pkg::RESP_SLVERR
                                                                  : iom_pkg::RESP_OKAY;
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end else if (s_axi_arvalid && !s_axi_rvalid) begin
        s_axi_arready <= 1'b1;
      end
    end
  end

  // Load data one edge after the request
  always_ff @(posedge mclk) begin
    if (reset) begin
      iob_rdata <= 32'h0000_0000;
    end else if (ce && iob_sel && !iob_we) begin
      iob_rdata <= read_word(iob_addr);
    end
  end

  // ---------------------------------------------------------------
  // Pin slices
  // ---------------------------------------------------------------
  genvar p;
  generate
    for (p = 0; p < iom_pkg::NPIN; p++) begin : g_pin
      logic [7:0] fo;
      logic [7:0] fe;
      for (genvar f = 0; f < iom_pkg::NFUNC; f++) begin : g_fn
        assign fo[f] = periph_out[f * iom_pkg::NPIN + p];
        assign fe[f] = periph_oe[f * iom_pkg::NPIN + p];
      end
      // Enabled, legal code, and debug data gated by probe presence
      assign pin_act[p] = cfg_en_reg[p] && !sel_reg[p][3]
        && !(p == iom_pkg::PIN_DBG_DATA && sel_reg[p] == iom_pkg::FUNC_H
             && !debugger_present);
      iom_pin_slice u_slice (
        .mclk(mclk),
        .reset(reset),
        .ce(ce),
        .gpio_out(out_reg[p]),
        .gpio_dir(dir_reg[p]),
        .gpio_inen(cfg_inen_reg[p]),
        .func_act(pin_act[p]),
        .func_sel(sel_reg[p]),
        .osc_own(osc_own[p]),
        .fn_out(fo),
        .fn_oe(fe),
        .pad_in(pad_in[p]),
        .pad_out(pad_out[p]),
        .pad_oe(pad_oe[p]),
        .pad_ie(pad_ie[p]),
        .pad_analog_en(pad_analog_en[p]),
        .fn_active(periph_func_active[p]),
        .fn_in(periph_in[p])
      );
    end
  endgenerate

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  a_gpio_default: assert property (@(posedge mclk) disable iff (reset)
    ce && !pin_act[5] && !osc_own[5] |=> pad_oe[5] == $past(dir_reg[5])
      && pad_out[5] == $past(out_reg[5]))
    else $error("port does not own an unmuxed pin");
  a_enable_needed: assert property (@(posedge mclk) disable iff (reset)
    ce && !cfg_en_reg[4] |=> !periph_func_active[4])
    else $error("function active without enable");
  a_func_route: assert property (@(posedge mclk) disable iff (reset)
    ce && pin_act[4] && sel_reg[4] == iom_pkg::FUNC_C && !osc_own[4]
      |=> pad_out[4] == $past(periph_out[2 * iom_pkg::NPIN + 4]))
    else $error("function C not routed");
  a_analog_cut: assert property (@(posedge mclk) disable iff (reset)
    ce && pin_act[5] && sel_reg[5] == iom_pkg::FUNC_B
      |=> !pad_oe[5] && !pad_ie[5] && pad_analog_en[5])
    else $error("digital control left on analog pin");
  a_swdio_gate: assert property (@(posedge mclk) disable iff (reset)
    ce && !debugger_present && sel_reg[31] == iom_pkg::FUNC_H |=> !periph_func_active[31])
    else $error("debug data live without debugger");
  a_swclk_reset: assert property (@(posedge mclk)
    $fell(reset) |-> cfg_en_reg[30] && sel_reg[30] == iom_pkg::FUNC_G)
    else $error("debug clock not selected after reset");
  a_swclk_release: assert property (@(posedge mclk) disable iff (reset)
    ce && wp_en && wp_mask[0] && wp_addr == 8'hF8 && !wp_data[0] && !debug_mode
      && !(debugger_present && !dbg_prev_reg) |=> !cfg_en_reg[30])
    else $error("debug clock pin not released");
  a_swdio_attach: assert property (@(posedge mclk) disable iff (reset)
    ce && debugger_present && !dbg_prev_reg
      |=> cfg_en_reg[31] && sel_reg[31] == iom_pkg::FUNC_H ##1 !pad_oe[31] || pin_act[31])
    else $error("debug data not taken on attach");
  a_dbg_lock: assert property (@(posedge mclk) disable iff (reset)
    debug_mode && $stable(debug_mode) |-> dir_reg[31:30] == $past(dir_reg[31:30])
      && out_reg[31:30] == $past(out_reg[31:30]))
    else $error("debug pin port state changed in debug mode");
  a_osc_owned: assert property (@(posedge mclk) disable iff (reset)
    ce && osc_xosc_en |=> !pad_oe[14] && !pad_oe[15])
    else $error("oscillator pin driven by port");
  a_iob_store_load: assert property (@(posedge mclk) disable iff (reset)
    ce && iob_wr && iob_addr == iom_pkg::OFF_DIR && !debug_mode ##1 !wp_en
      ##1 ce && iob_sel && !iob_we && iob_addr == iom_pkg::OFF_DIR && !debug_mode
      |=> iob_rdata == $past(iob_wdata, 3))
    else $error("store then load not single cycle");
endmodule : iom_pin_mux

// File: test/iom_periph_model.sv
// Purpose: Peripheral side model driving the flat function buses
// Assumes: Function f of pin n sits at bit f*32+n
// Notes: Pattern inverts with flip so stale pad values show
`timescale 1ns/1ns
module iom_periph_model (
  input wire logic flip,
  input wire logic [31:0] periph_in,
  output logic [255:0] periph_out,
  output logic [255:0] periph_oe
);
  // Lane pattern; serial modules stay out of two-wire mode here
  always_comb begin
    for (int i = 0; i < 256; i++) begin
      periph_out[i] = i[0] ^ i[5] ^ flip;
      periph_oe[i] = i[1] ^ i[6] ^ flip;
    end
  end
endmodule : iom_periph_model

// File: test/testbench.sv
// Purpose: Self-checking bench for the pin function multiplexer
// Assumes: AXI4-Lite and I/O bus tasks, peripheral model on far side
// Notes: Pads are checked a few edges after each config change
`timescale 1ns/1ns
`define CHK(n, e, g) begin comparisons++; if ((g) !== (e)) begin miscompares++; \
  $display("wrong value %s exp %h got %h", n, e, g); end end
module testbench;
  logic mclk = 1'h0, reset = 1'h1, flip = 1'h0, awv = 1'h0, wv = 1'h0, bre = 1'h0;
  logic arv = 1'h0, rre = 1'h0, sel = 1'h0, we = 1'h0, dbg = 1'h0, dm = 1'h0;
  logic xo = 1'h0, xo32 = 1'h0;
  logic [7:0] awa = 8'h00, ara = 8'h00, ia = 8'h00;
  logic [31:0] wd = 32'h0, iwd = 32'h0, pin = 32'h0, rd;
  logic [3:0] g;
  wire logic awr, wr, bv, arr, rv;
  wire logic [1:0] br, rr;
  wire logic [31:0] rdt, ird, po, poe, pie, pan, pfi, pfa;
  wire logic [255:0] fo, foe;
  int miscompares = 0, comparisons = 0, w = 0;
  always #5 mclk = ~mclk;
  iom_periph_model i_far (.flip(flip), .periph_in(pfi), .periph_out(fo), .periph_oe(foe));
  iom_pin_mux i_dut (.mclk(mclk), .reset(reset), .ce(1'h1), .s_axi_awvalid(awv),
    .s_axi_awready(awr), .s_axi_awaddr(awa), .s_axi_awprot(3'h0), .s_axi_wvalid(wv),
    .s_axi_wready(wr), .s_axi_wdata(wd), .s_axi_wstrb(4'hF), .s_axi_bvalid(bv),
    .s_axi_bready(bre), .s_axi_bresp(br), .s_axi_arvalid(arv), .s_axi_arready(arr),
    .s_axi_araddr(ara), .s_axi_arprot(3'h0), .s_axi_rvalid(rv), .s_axi_rready(rre),
    .s_axi_rdata(rdt), .s_axi_rresp(rr), .iob_sel(sel), .iob_we(we), .iob_addr(ia),
    .iob_wdata(iwd), .iob_rdata(ird), .debugger_present(dbg), .debug_mode(dm),
    .osc_xosc_en(xo), .osc_xosc32k_en(xo32), .pad_in(pin), .pad_out(po), .pad_oe(poe),
    .pad_ie(pie), .pad_analog_en(pan), .periph_out(fo), .periph_oe(foe),
    .periph_in(pfi), .periph_func_active(pfa));
  // ---------------------------------------------------------------
  // Bus tasks
  // ---------------------------------------------------------------
  task close_out;
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : close_out
  // One edge with a bounded wait
  task tick;
    @(posedge mclk);
    w++;
    if (w > 200) begin
      miscompares++;
      close_out;
    end
  endtask : tick
  task axw(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    logic ad;
    logic dd;
    ad = 1'h0;
    dd = 1'h0;
    w = 0;
    awa <= a;
    wd <= d;
    awv <= 1'h1;
    wv <= 1'h1;
    bre <= 1'h1;
    while (!(ad && dd)) begin
      tick;
      if (awr) begin
        ad = 1'h1;
        awv <= 1'h0;
      end
      if (wr) begin
        dd = 1'h1;
        wv <= 1'h0;
      end
    end
    while (!bv) tick;
    bre <= 1'h0;
    `CHK("bresp", er, br)
  endtask : axw
  task axr(input logic [7:0] a, output logic [31:0] d, input logic [1:0] er);
    w = 0;
    ara <= a;
    arv <= 1'h1;
    rre <= 1'h1;
    do tick; while (!arr);
    arv <= 1'h0;
    while (!rv) tick;
    rre <= 1'h0;
    d = rdt;
    `CHK("rresp", er, rr)
  endtask : axr
  task iobw(input logic [7:0] a, input logic [31:0] d);
    ia <= a;
    iwd <= d;
    sel <= 1'h1;
    we <= 1'h1;
    @(posedge mclk);
    sel <= 1'h0;
    we <= 1'h0;
    @(posedge mclk);
  endtask : iobw
  task iobr(input logic [7:0] a, output logic [31:0] d);
    ia <= a;
    sel <= 1'h1;
    @(posedge mclk);
    sel <= 1'h0;
    @(posedge mclk);
    d = ird;
  endtask : iobr
  // ---------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------
  initial begin
    repeat (16) @(posedge mclk);
    reset <= 1'h0;
    @(posedge mclk);
    axr(8'hF8, rd, iom_pkg::RESP_OKAY);
    `CHK("cfg30", 32'h1, rd & 32'h1)
    axr(8'h7C, rd, iom_pkg::RESP_OKAY);
    `CHK("mux15", 8'h06, rd[7:0])
    `CHK("oe30", foe[222], poe[30])
    `CHK("act30", 1'h1, pfa[30])
    `CHK("act31", 1'h0, pfa[31])
    // Store then load of the same word, one idle edge apart
    iobw(iom_pkg::OFF_DIR, 32'h0000_0030);
    iobr(iom_pkg::OFF_DIR, rd);
    `CHK("dir", 32'h0000_0030, rd)
    iobw(iom_pkg::OFF_OUT, 32'h0000_0020);
    repeat (3) @(posedge mclk);
    `CHK("oe54", 2'h3, poe[5:4])
    `CHK("out54", 2'h2, po[5:4])
    axw(8'h90, 32'h1, iom_pkg::RESP_OKAY);
    axw(8'h94, 32'h1, iom_pkg::RESP_OKAY);
    pin <= 32'h0000_0030;
    // Every function code on the odd field, the reverse on the even one
    for (logic [3:0] f = 4'h0; f < 4'h8; f++) begin
      g = 4'h7 - f;
      flip <= f[0];
      axw(8'h48, {24'h0, f, g}, iom_pkg::RESP_OKAY);
      repeat (3) @(posedge mclk);
      if (f == iom_pkg::FUNC_B) begin
        `CHK("ana5", 4'h9, {pan[5], poe[5], pie[5], pfa[5]})
      end else begin
        `CHK("oe5", foe[f * 32 + 5], poe[5])
        `CHK("out5", fo[f * 32 + 5], po[5])
        `CHK("in5", 1'h1, pfi[5])
        `CHK("ie5", 1'h1, pie[5])
      end
      `CHK("oe4", (g == iom_pkg::FUNC_B) ? 1'h0 : foe[g * 32 + 4], poe[4])
    end
    axw(8'h90, 32'h0, iom_pkg::RESP_OKAY);
    axw(8'hF8, 32'h0, iom_pkg::RESP_OKAY);
    repeat (3) @(posedge mclk);
    `CHK("oe4port", 1'h1, poe[4])
    `CHK("pin30", 2'h0, {poe[30], pfa[30]})
    dbg <= 1'h1;
    repeat (3) @(posedge mclk);
    `CHK("act31on", 1'h1, pfa[31])
    `CHK("oe31", foe[255], poe[31])
    axr(iom_pkg::OFF_STAT, rd, iom_pkg::RESP_OKAY);
    `CHK("stat", 3'h6, rd[2:0])
    dm <= 1'h1;
    iobw(iom_pkg::OFF_DIR, 32'hFFFF_FFFF);
    axw(8'h7C, 32'h0, iom_pkg::RESP_OKAY);
    axr(8'h7C, rd, iom_pkg::RESP_OKAY);
    `CHK("mux15lk", 32'h0, rd)
    dm <= 1'h0;
    iobr(iom_pkg::OFF_DIR, rd);
    `CHK("dirlk", 32'h3FFF_FFFF, rd)
    axr(8'h7C, rd, iom_pkg::RESP_OKAY);
    `CHK("mux15h", 8'h76, rd[7:0])
    xo <= 1'h1;
    xo32 <= 1'h1;
    repeat (3) @(posedge mclk);
    `CHK("xosc", 8'h0F, {poe[15:14], poe[1:0], pan[15:14], pan[1:0]})
    axr(8'h20, rd, iom_pkg::RESP_SLVERR);
    `CHK("unmap", 32'h0, rd)
    axw(8'h82, 32'h1, iom_pkg::RESP_SLVERR);
    // Probe leaves: pin 31 falls back to port control
    dbg <= 1'h0;
    repeat (3) @(posedge mclk);
    `CHK("act31off", 1'h0, pfa[31])
    `CHK("oe31port", 1'h0, poe[31])
    close_out;
  end
endmodule : testbench
